// *** src/state_regs_pkg.sv ***
// constants for the device state register block
package state_regs_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_REQ_LO = 16'h0120;
    localparam logic [15:0] ADDR_REQ_HI = 16'h0121;
    localparam logic [15:0] ADDR_STAT_LO = 16'h0130;
    localparam logic [15:0] ADDR_STAT_HI = 16'h0131;
    localparam logic [15:0] ADDR_CODE_LO = 16'h0134;
    localparam logic [15:0] ADDR_CODE_HI = 16'h0135;
    localparam logic [15:0] ADDR_RUN_OVR = 16'h0138;
    localparam logic [15:0] ADDR_ERR_OVR = 16'h0139;
    localparam logic [15:0] ADDR_IF_SEL = 16'h0140;
    localparam logic [15:0] ADDR_CONFIG = 16'h0141;
    // field positions
    localparam int STATE_MSB = 3;
    localparam int ERR_ACK_BIT = 4;
    localparam int IDENT_REQ_BIT = 5;
    localparam int ERR_IND_BIT = 4;
    localparam int IDENT_OK_BIT = 5;
    localparam int OVR_EN_BIT = 4;
    localparam int MIRROR_BIT = 0;
    // state codes
    localparam logic [3:0] ST_INIT = 4'h1;
    localparam logic [3:0] ST_PRE_OPER = 4'h2;
    localparam logic [3:0] ST_BOOT = 4'h3;
    localparam logic [3:0] ST_SAFE_OPER = 4'h4;
    localparam logic [3:0] ST_OP = 4'h8;
    // indicator pattern codes
    localparam logic [3:0] LED_OFF = 4'h0;
    localparam logic [3:0] LED_FLASH1 = 4'h1;
    localparam logic [3:0] LED_BLINK = 4'hD;
    localparam logic [3:0] LED_FLICKER = 4'hE;
    localparam logic [3:0] LED_ON = 4'hF;
    // interface select values
    localparam logic [7:0] IF_NONE = 8'h00;
    localparam logic [7:0] IF_SERIAL = 8'h05;
    localparam logic [7:0] IF_ONCHIP = 8'h80;
    // reset values
    localparam logic [15:0] REQ_RESET = 16'h0000;
    localparam logic [15:0] STAT_RESET = 16'h0001;
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [7:0] OVR_RESET = 8'h00;
    localparam logic [7:0] IF_SEL_RESET = 8'h00;
endpackage

// *** src/device_state_register_block.sv ***
// application-layer state registers shared by frame-side master and host port
`timescale 1ns/1ps
module device_state_register_block (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // frame-side master byte access
    input wire logic [15:0] fsm_addr,
    input wire logic fsm_wr,
    input wire logic fsm_rd,
    input wire logic [7:0] fsm_wdata,
    output logic [7:0] fsm_rdata,
    // host process port byte access
    input wire logic [15:0] hpp_addr,
    input wire logic hpp_wr,
    input wire logic hpp_rd,
    input wire logic [7:0] hpp_wdata,
    output logic [7:0] hpp_rdata,
    // configuration load
    input wire logic cfg_load,
    input wire logic [7:0] cfg_if_sel,
    input wire logic [7:0] cfg_config,
    input wire logic ack_by_write,
    input wire logic ident_loaded,
    input wire logic local_error,
    // event and indicator outputs
    output logic master_evt3,
    output logic host_evt0,
    output logic [3:0] run_code,
    output logic [3:0] err_code
);
    // ==========================================
    // overview
    // two byte-wide ports reach one set of registers. the frame-side
    // master owns the request register and the host owns the status
    // register, unless mirror mode hands the status to the master.
    // both ports decode the same byte map, so a register shows one
    // value to both sides. strobes last one cycle and carry their
    // address and data with them; back-to-back strobes are fine.
    // nothing here waits: every write lands at the edge that samples
    // it and every read answers one cycle later.
    // the request register is a one-deep mailbox between the master
    // and the host; a master write that finds it full is dropped.

    // ==========================================
    // register state
    logic [15:0] req_ff; // state request, low byte stored
    logic [15:0] stat_ff; // actual state and flags
    logic [15:0] code_ff; // host-owned status code
    logic [7:0] run_ovr_ff; // run indicator override
    logic [7:0] err_ovr_ff; // error indicator override
    logic [7:0] if_sel_ff; // interface select byte
    logic [7:0] config_ff; // configuration byte, bit 0 mirror
    logic locked_ff; // mailbox holds an unacknowledged request
    logic master_evt3_ff;
    logic host_evt0_ff;
    logic err_prev_ff; // last sampled error level
    logic [7:0] fsm_rdata_ff;
    logic [7:0] hpp_rdata_ff;

    // decoded strobes and next values
    logic mirror;
    logic m_req_wr;
    logic h_req_rd;
    logic h_req_wr;
    logic h_req_ack;
    logic m_req_ok;
    logic h_stat_wr;
    logic stat_valid;
    logic nxt_err_rise;
    logic [15:0] nxt_stat;
    logic [3:0] run_int;
    logic [3:0] err_int;

    // width of the state code field, fixed by the code set
    localparam int STATE_W = state_regs_pkg::STATE_MSB + 1;

    // ==========================================
    // access decode
    // both byte addresses of the request and status registers decode alike, so the
    // mailbox does not care which half a port touches. the master and
    // the host may strobe in the same cycle; they are decoded apart
    // and each register states below which of them wins a tie.
    // addresses match exactly, so no alias of a register exists
    // mirror mode bit
    assign mirror = config_ff[state_regs_pkg::MIRROR_BIT];
    assign m_req_wr = fsm_wr && (fsm_addr == state_regs_pkg::ADDR_REQ_LO ||
                                 fsm_addr == state_regs_pkg::ADDR_REQ_HI);
    assign h_req_rd = hpp_rd && (hpp_addr == state_regs_pkg::ADDR_REQ_LO ||
                                 hpp_addr == state_regs_pkg::ADDR_REQ_HI);
    assign h_req_wr = hpp_wr && (hpp_addr == state_regs_pkg::ADDR_REQ_LO ||
                                 hpp_addr == state_regs_pkg::ADDR_REQ_HI);
    assign h_req_ack = ack_by_write ? h_req_wr : h_req_rd;
    // mailbox gate, open always when mirroring
    assign m_req_ok = m_req_wr && (mirror || !locked_ff);
    // host status writes only without mirror
    assign h_stat_wr = hpp_wr && !mirror && (hpp_addr == state_regs_pkg::ADDR_STAT_LO ||
                                             hpp_addr == state_regs_pkg::ADDR_STAT_HI);

    // ==========================================
    // state request register
    // only the low byte holds defined bits: the upper byte reads zero
    // and a write to it is dropped, which keeps reserved bits clean
    // even when a master writes them by mistake
    // reserved bits dropped; host write value ignored
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            req_ff <= state_regs_pkg::REQ_RESET;
        end else if (m_req_ok) begin
            if (fsm_addr[0] == 1'b0) begin
                req_ff[7:0] <= {2'b00, fsm_wdata[5:0]};
            end
        end
    end

    // mailbox lock; a new write in the ack cycle wins the lock only if it was empty
    // m_req_ok shuts while locked, so a write in the ack cycle of a held request
    // is dropped; the host event clears and the older value stays in place
    // empty after reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            locked_ff <= 1'b0;
        end else if (m_req_ok && !mirror) begin
            locked_ff <= 1'b1;
        end else if (h_req_ack || mirror) begin
            locked_ff <= 1'b0;
        end
    end

    // ==========================================
    // actual-state register
    // one next-value process gathers every writer, so the event and the
    // override clears below compare against a single settled value;
    // a raised error is applied last and so wins over an acknowledge
    always_comb begin
        nxt_stat = stat_ff;
        if (mirror && m_req_ok && fsm_addr[0] == 1'b0) begin
            nxt_stat[STATE_W-1:0] = fsm_wdata[3:0];
            if (fsm_wdata[state_regs_pkg::ERR_ACK_BIT]) begin
                nxt_stat[state_regs_pkg::ERR_IND_BIT] = 1'b0;
            end
        end else if (h_stat_wr && hpp_addr[0] == 1'b0) begin
            nxt_stat[4:0] = hpp_wdata[4:0];
        end
        if (nxt_err_rise) begin
            nxt_stat[state_regs_pkg::ERR_IND_BIT] = 1'b1;
        end
        nxt_stat[state_regs_pkg::IDENT_OK_BIT] = ident_loaded;
        nxt_stat[15:6] = 10'h000;
    end

    // the whole word is registered each cycle; reserved bits are forced
    // to zero in the next-value process, never here
    // current state code kept here
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stat_ff <= state_regs_pkg::STAT_RESET;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    // new error condition detect
    // limitation: a level held high raises one error only; the source
    // must drop and raise it again to report a further error
    assign nxt_err_rise = local_error && !err_prev_ff;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            err_prev_ff <= 1'b0;
        end else begin
            err_prev_ff <= local_error;
        end
    end

    // ==========================================
    // status code, host writable only
    // the master only reads it; the host puts the reason for a refused
    // transition here before raising the error flag
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            code_ff <= state_regs_pkg::CODE_RESET;
        end else if (hpp_wr && hpp_addr == state_regs_pkg::ADDR_CODE_LO) begin
            code_ff[7:0] <= hpp_wdata;
        end else if (hpp_wr && hpp_addr == state_regs_pkg::ADDR_CODE_HI) begin
            code_ff[15:8] <= hpp_wdata;
        end
    end

    // ==========================================
    // event request flags; set wins over clear
    // a clear in the same cycle as a new set would drop a fresh event,
    // so the set branch is tested first in both flags
    // host event: a request accepted from the master
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            host_evt0_ff <= 1'b0;
        end else if (m_req_ok) begin
            host_evt0_ff <= 1'b1;
        end else if (h_req_ack) begin
            host_evt0_ff <= 1'b0;
        end
    end

    // master event: any change of the status word, ident bit included
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            master_evt3_ff <= 1'b0;
        end else if (nxt_stat != stat_ff) begin
            master_evt3_ff <= 1'b1;
        end else if (fsm_rd && (fsm_addr == state_regs_pkg::ADDR_STAT_LO ||
                                fsm_addr == state_regs_pkg::ADDR_STAT_HI)) begin
            master_evt3_ff <= 1'b0;
        end
    end
    assign master_evt3 = master_evt3_ff;
    assign host_evt0 = host_evt0_ff;

    // ==========================================
    // indicator overrides
    // an override is a debug aid; a change to a valid state code hands the run indicator back,
    // and a rising local_error the error indicator, to internal status so it cannot hide
    // a fault from the operator
    assign stat_valid = nxt_stat[3:0] == state_regs_pkg::ST_INIT ||
                        nxt_stat[3:0] == state_regs_pkg::ST_PRE_OPER ||
                        nxt_stat[3:0] == state_regs_pkg::ST_BOOT ||
                        nxt_stat[3:0] == state_regs_pkg::ST_SAFE_OPER ||
                        nxt_stat[3:0] == state_regs_pkg::ST_OP;

    // run override: host and master may both write it
    // code and enable written by either side, host wins a tie
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            run_ovr_ff <= state_regs_pkg::OVR_RESET;
        end else begin
            if (hpp_wr && hpp_addr == state_regs_pkg::ADDR_RUN_OVR) begin
                run_ovr_ff <= {3'b000, hpp_wdata[4:0]};
            end else if (fsm_wr && fsm_addr == state_regs_pkg::ADDR_RUN_OVR) begin
                run_ovr_ff <= {3'b000, fsm_wdata[4:0]};
            end
            if (nxt_stat[3:0] != stat_ff[3:0] && stat_valid) begin
                run_ovr_ff[state_regs_pkg::OVR_EN_BIT] <= 1'b0;
            end
        end
    end

    // error override, same layout as the run override
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            err_ovr_ff <= state_regs_pkg::OVR_RESET;
        end else begin
            if (hpp_wr && hpp_addr == state_regs_pkg::ADDR_ERR_OVR) begin
                err_ovr_ff <= {3'b000, hpp_wdata[4:0]};
            end else if (fsm_wr && fsm_addr == state_regs_pkg::ADDR_ERR_OVR) begin
                err_ovr_ff <= {3'b000, fsm_wdata[4:0]};
            end
            if (nxt_err_rise) begin
                err_ovr_ff[state_regs_pkg::OVR_EN_BIT] <= 1'b0;
            end
        end
    end

    // a code outside the set, left by a host write, shows as off
    // internal patterns from state and error
    always_comb begin
        unique case (stat_ff[3:0])
            state_regs_pkg::ST_INIT: run_int = state_regs_pkg::LED_OFF;
            state_regs_pkg::ST_PRE_OPER: run_int = state_regs_pkg::LED_BLINK;
            state_regs_pkg::ST_BOOT: run_int = state_regs_pkg::LED_FLICKER;
            state_regs_pkg::ST_SAFE_OPER: run_int = state_regs_pkg::LED_FLASH1;
            state_regs_pkg::ST_OP: run_int = state_regs_pkg::LED_ON;
            default: run_int = state_regs_pkg::LED_OFF;
        endcase
        err_int = stat_ff[state_regs_pkg::ERR_IND_BIT] ? state_regs_pkg::LED_ON :
                  state_regs_pkg::LED_OFF;
    end

    assign run_code = run_ovr_ff[state_regs_pkg::OVR_EN_BIT] ? run_ovr_ff[3:0] : run_int;
    assign err_code = err_ovr_ff[state_regs_pkg::OVR_EN_BIT] ? err_ovr_ff[3:0] : err_int;

    // ==========================================
    // configuration bytes
    // the select byte has no bus write path at all; only the load from
    // configuration memory changes it, and a load in the same cycle as
    // a master write to the mirror bit takes precedence
    // select byte only from configuration load
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            if_sel_ff <= state_regs_pkg::IF_SEL_RESET;
            config_ff <= 8'h00;
        end else if (cfg_load) begin
            if_sel_ff <= cfg_if_sel;
            config_ff <= cfg_config;
        end else if (fsm_wr && fsm_addr == state_regs_pkg::ADDR_CONFIG) begin
            config_ff[state_regs_pkg::MIRROR_BIT] <= fsm_wdata[state_regs_pkg::MIRROR_BIT];
        end
    end

    // ==========================================
    // read data, registered one cycle after the strobe
    // registering the read data costs one cycle of latency but keeps
    // the decode off the port output path; the value then stands
    // until the next read on that port
    function automatic logic [7:0] rd_mux(input logic [15:0] a);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            state_regs_pkg::ADDR_REQ_LO: r = req_ff[7:0];
            state_regs_pkg::ADDR_REQ_HI: r = req_ff[15:8];
            state_regs_pkg::ADDR_STAT_LO: r = stat_ff[7:0];
            state_regs_pkg::ADDR_STAT_HI: r = stat_ff[15:8];
            state_regs_pkg::ADDR_CODE_LO: r = code_ff[7:0];
            state_regs_pkg::ADDR_CODE_HI: r = code_ff[15:8];
            state_regs_pkg::ADDR_RUN_OVR: r = {3'b000, run_ovr_ff[4], run_code};
            state_regs_pkg::ADDR_ERR_OVR: r = {3'b000, err_ovr_ff[4], err_code};
            state_regs_pkg::ADDR_IF_SEL: r = if_sel_ff;
            state_regs_pkg::ADDR_CONFIG: r = config_ff;
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // master read data
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fsm_rdata_ff <= 8'h00;
        end else if (fsm_rd) begin
            fsm_rdata_ff <= rd_mux(fsm_addr);
        end
    end

    // host read data
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hpp_rdata_ff <= 8'h00;
        end else if (hpp_rd) begin
            hpp_rdata_ff <= rd_mux(hpp_addr);
        end
    end
    assign fsm_rdata = fsm_rdata_ff;
    assign hpp_rdata = hpp_rdata_ff;
endmodule

// *** sim/device_state_register_block_assertions.sv ***
// port checker for the device state register block
`timescale 1ns/1ps
module device_state_register_block_assertions (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // frame-side master
    input wire logic [15:0] fsm_addr,
    input wire logic fsm_wr,
    input wire logic fsm_rd,
    input wire logic [7:0] fsm_rdata,
    // host process port
    input wire logic [15:0] hpp_addr,
    input wire logic hpp_wr,
    input wire logic hpp_rd,
    input wire logic [7:0] hpp_rdata,
    // levels and outputs
    input wire logic ack_by_write,
    input wire logic ident_loaded,
    input wire logic local_error,
    input wire logic master_evt3,
    input wire logic host_evt0,
    input wire logic [3:0] run_code,
    input wire logic [3:0] err_code
);
    // a master write in the same cycle may relock, so those cycles are left out
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    AST_MST_STAT_RD: assert property (fsm_rd && fsm_addr == state_regs_pkg::ADDR_STAT_LO
        |=> !master_evt3) else $error("master status read left event set");
    AST_HOST_RD_ACK: assert property (hpp_rd && hpp_addr == state_regs_pkg::ADDR_REQ_LO
        && !ack_by_write && !fsm_wr |=> !host_evt0) else $error("host read kept event");
    AST_HOST_HI_ACK: assert property (hpp_rd && hpp_addr == state_regs_pkg::ADDR_REQ_HI
        && !ack_by_write && !fsm_wr |=> !host_evt0) else $error("upper byte read kept event");
    AST_HOST_WR_ACK: assert property (hpp_wr && hpp_addr == state_regs_pkg::ADDR_REQ_LO
        && ack_by_write && !fsm_wr |=> !host_evt0) else $error("host write kept event");
    AST_IDENT_BIT: assert property (hpp_rd && hpp_addr == state_regs_pkg::ADDR_STAT_LO
        |=> hpp_rdata[5] == $past(ident_loaded, 2)) else $error("identification bit wrong");
    AST_RUN_READ: assert property (fsm_rd && fsm_addr == state_regs_pkg::ADDR_RUN_OVR
        |=> fsm_rdata[3:0] == $past(run_code)) else $error("run override read wrong");
    AST_ERR_READ: assert property (hpp_rd && hpp_addr == state_regs_pkg::ADDR_ERR_OVR
        |=> hpp_rdata[3:0] == $past(err_code)) else $error("error override read wrong");
    AST_NEW_ERR: assert property ($rose(local_error)
        |-> ##[1:2] err_code == state_regs_pkg::LED_ON) else $error("new error not shown");
endmodule

// *** sim/bus_agent.sv ***
// master and host byte access model facing the register block
`timescale 1ns/1ps
module bus_agent (
    // clock
    input wire logic ref_clk,
    // frame-side master
    output wire logic [15:0] fsm_addr,
    output wire logic fsm_wr,
    output wire logic fsm_rd,
    output wire logic [7:0] fsm_wdata,
    input wire logic [7:0] fsm_rdata,
    // host process port
    output wire logic [15:0] hpp_addr,
    output wire logic hpp_wr,
    output wire logic hpp_rd,
    output wire logic [7:0] hpp_wdata,
    input wire logic [7:0] hpp_rdata
);
    logic [15:0] addr_q = 16'h0000;
    logic [7:0] data_q = 8'h00;
    logic wr_q = 1'b0;
    logic rd_q = 1'b0;
    logic host_q = 1'b0;
    // one shared bus, strobes steered to the chosen port
    assign fsm_addr = addr_q;
    assign hpp_addr = addr_q;
    assign fsm_wdata = data_q;
    assign hpp_wdata = data_q;
    assign fsm_wr = wr_q & ~host_q;
    assign fsm_rd = rd_q & ~host_q;
    assign hpp_wr = wr_q & host_q;
    assign hpp_rd = rd_q & host_q;
    // one-cycle strobe; lines inverted once released so stale values never look valid
    task automatic access(input logic host, input logic wr, input logic [15:0] a,
            input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        host_q <= host;
        addr_q <= a;
        data_q <= d;
        wr_q <= wr;
        rd_q <= ~wr;
        @(posedge ref_clk);
        wr_q <= 1'b0;
        rd_q <= 1'b0;
        addr_q <= ~a;
        data_q <= ~d;
        // read data stands from the strobe edge until the next read
        @(posedge ref_clk);
        q = host ? hpp_rdata : fsm_rdata;
    endtask
endmodule

// *** sim/tb_device_state_register_block.sv ***
// self-checking bench for the device state register block
`timescale 1ns/1ps
module tb_device_state_register_block;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic cfg_load = 1'b0;
    logic [7:0] cfg_if_sel = 8'h00;
    logic [7:0] cfg_config = 8'h00;
    logic ack_by_write = 1'b0;
    logic ident_loaded = 1'b0;
    logic local_error = 1'b0;
    logic [15:0] fsm_addr, hpp_addr;
    logic fsm_wr, fsm_rd, hpp_wr, hpp_rd, master_evt3, host_evt0;
    logic [7:0] fsm_wdata, fsm_rdata, hpp_wdata, hpp_rdata, q;
    logic [3:0] run_code, err_code;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    // ===========================================================
    // clock, instances, hang guard
    always #2.5 ref_clk = ~ref_clk;
    device_state_register_block device_state_register_block_inst (.ref_clk(ref_clk),
        .resetn(resetn), .fsm_addr(fsm_addr), .fsm_wr(fsm_wr), .fsm_rd(fsm_rd),
        .fsm_wdata(fsm_wdata), .fsm_rdata(fsm_rdata), .hpp_addr(hpp_addr), .hpp_wr(hpp_wr),
        .hpp_rd(hpp_rd), .hpp_wdata(hpp_wdata), .hpp_rdata(hpp_rdata), .cfg_load(cfg_load),
        .cfg_if_sel(cfg_if_sel), .cfg_config(cfg_config), .ack_by_write(ack_by_write),
        .ident_loaded(ident_loaded), .local_error(local_error), .master_evt3(master_evt3),
        .host_evt0(host_evt0), .run_code(run_code), .err_code(err_code));
    bus_agent bus_agent_inst (.ref_clk(ref_clk), .fsm_addr(fsm_addr), .fsm_wr(fsm_wr),
        .fsm_rd(fsm_rd), .fsm_wdata(fsm_wdata), .fsm_rdata(fsm_rdata), .hpp_addr(hpp_addr),
        .hpp_wr(hpp_wr), .hpp_rd(hpp_rd), .hpp_wdata(hpp_wdata), .hpp_rdata(hpp_rdata));
    // the whole run is about 120 cycles, so this only trips on a hang
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            give_verdict();
        end
    end
    // ===========================================================
    // shared helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic host, input logic wr, input logic [15:0] a,
            input logic [7:0] d);
        bus_agent_inst.access(host, wr, a, d, q);
    endtask
    task automatic give_verdict();
        $display("errors %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ===========================================================
    // scenarios
    task automatic s_reset();
        acc(1, 0, state_regs_pkg::ADDR_STAT_LO, 8'h00);
        check(q, 8'h01);
        check({4'h0, run_code}, 8'h00);
        acc(1, 0, state_regs_pkg::ADDR_IF_SEL, 8'h00);
        check(q, 8'h00);
        check({7'h0, host_evt0}, 8'h00);
    endtask
    task automatic s_error();
        acc(1, 1, state_regs_pkg::ADDR_ERR_OVR, 8'h1D);
        check({4'h0, err_code}, 8'h0D);
        @(posedge ref_clk);
        local_error <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check({4'h0, err_code}, 8'h0F);
        acc(1, 0, state_regs_pkg::ADDR_ERR_OVR, 8'h00);
        check({3'h0, q[4:0]}, 8'h0F);
        acc(1, 0, state_regs_pkg::ADDR_STAT_LO, 8'h00);
        check(q, 8'h11);
    endtask
    task automatic s_mailbox();
        acc(0, 1, state_regs_pkg::ADDR_REQ_LO, 8'h02);
        check({7'h0, host_evt0}, 8'h01);
        acc(0, 1, state_regs_pkg::ADDR_REQ_LO, 8'h04);
        acc(1, 1, state_regs_pkg::ADDR_REQ_LO, 8'hFF);
        acc(1, 0, state_regs_pkg::ADDR_REQ_LO, 8'h00);
        check(q, 8'h02);
        check({7'h0, host_evt0}, 8'h00);
        acc(0, 1, state_regs_pkg::ADDR_REQ_LO, 8'h14);
        acc(1, 0, state_regs_pkg::ADDR_REQ_HI, 8'h00);
        check({7'h0, host_evt0}, 8'h00);
        acc(1, 0, state_regs_pkg::ADDR_STAT_LO, 8'h00);
        check(q, 8'h11);
        acc(0, 1, state_regs_pkg::ADDR_REQ_LO, 8'h08);
        acc(1, 0, state_regs_pkg::ADDR_REQ_LO, 8'h00);
        check(q, 8'h08);
        ack_by_write <= 1'b1;
        acc(0, 1, state_regs_pkg::ADDR_REQ_LO, 8'h01);
        acc(1, 1, state_regs_pkg::ADDR_REQ_LO, 8'h00);
        check({7'h0, host_evt0}, 8'h00);
        acc(1, 0, state_regs_pkg::ADDR_REQ_LO, 8'h00);
        check(q, 8'h01);
        ack_by_write <= 1'b0;
    endtask
    task automatic s_status();
        logic [3:0] st [4] = '{4'h4, 4'h2, 4'h3, 4'h1};
        logic [3:0] led [4] = '{4'h1, 4'hD, 4'hE, 4'h0};
        ident_loaded <= 1'b1;
        acc(1, 1, state_regs_pkg::ADDR_RUN_OVR, 8'h1F);
        acc(0, 0, state_regs_pkg::ADDR_RUN_OVR, 8'h00);
        check({4'h0, q[3:0]}, 8'h0F);
        for (int i = 0; i < 4; i++) begin
            acc(1, 1, state_regs_pkg::ADDR_STAT_LO, {4'h0, st[i]});
            check({4'h0, run_code}, {4'h0, led[i]});
            check({7'h0, master_evt3}, 8'h01);
            acc(0, 0, state_regs_pkg::ADDR_STAT_LO, 8'h00);
            check(q, {4'h2, st[i]});
            check({7'h0, master_evt3}, 8'h00);
        end
    endtask
    task automatic s_mirror();
        @(posedge ref_clk);
        cfg_config <= 8'h01;
        cfg_if_sel <= 8'h05;
        cfg_load <= 1'b1;
        @(posedge ref_clk);
        cfg_load <= 1'b0;
        acc(1, 1, state_regs_pkg::ADDR_IF_SEL, 8'h80);
        acc(0, 0, state_regs_pkg::ADDR_IF_SEL, 8'h00);
        check(q, 8'h05);
        acc(0, 1, state_regs_pkg::ADDR_REQ_LO, 8'h02);
        local_error <= 1'b0;
        @(posedge ref_clk);
        local_error <= 1'b1;
        acc(1, 0, state_regs_pkg::ADDR_STAT_LO, 8'h00);
        check(q, 8'h32);
        acc(0, 1, state_regs_pkg::ADDR_REQ_LO, 8'h18);
        acc(1, 0, state_regs_pkg::ADDR_STAT_LO, 8'h00);
        check(q, 8'h28);
        check({7'h0, q[4]}, 8'h00);
        acc(1, 1, state_regs_pkg::ADDR_STAT_LO, 8'h01);
        acc(1, 0, state_regs_pkg::ADDR_STAT_LO, 8'h00);
        check(q, 8'h28);
    endtask
    // ===========================================================
    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        s_reset();
        s_error();
        s_mailbox();
        s_status();
        s_mirror();
        give_verdict();
    end
endmodule
bind device_state_register_block device_state_register_block_assertions chk_inst (
    .ref_clk(ref_clk), .resetn(resetn), .fsm_addr(fsm_addr), .fsm_wr(fsm_wr), .fsm_rd(fsm_rd),
    .fsm_rdata(fsm_rdata), .hpp_addr(hpp_addr), .hpp_wr(hpp_wr), .hpp_rd(hpp_rd),
    .hpp_rdata(hpp_rdata), .ack_by_write(ack_by_write), .ident_loaded(ident_loaded),
    .local_error(local_error), .master_evt3(master_evt3), .host_evt0(host_evt0),
    .run_code(run_code), .err_code(err_code));
